// *** rtl/fifo_pm_pkg.sv ***
// constants shared by the fifo level / power management register ends and the host end
// What this block does
// - rx status used words, bits 23-16, reset zero
// - rx data used bytes, frames add rounded length
// - tx status used words, bits 23-16, reset zero
// - tx data free bytes, reset 1200h
// - host never writes beyond reported free space
// - power control register readable in any state
// - writes ignored until first read after wake
// - power state 00 full, 01 frame, 10 energy
// - byte test write wakes reduced power state
// - host writes only wake register while unready
// - transceiver reset bit holds 100us, self clears
// - energy enable raises interrupt and output
// - driver type clear means open drain low
// - wake cause 01 energy, 10 frame, 11 both
// - cause cleared by one when ready, sources idle
// - pulse select gives 50ms pulse, else level
// - output drops when cause or enable cleared
// - push-pull polarity bit picks active high
// - output enable gates only the pin
// - ready bit set once device has stabilised
package fifo_pm_pkg;
	// ----------------------------------------------------------------
	// link geometry and register offsets
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFS_RX_DATA = 8'h00;
	localparam logic [7:0] OFS_TX_DATA = 8'h20;
	localparam logic [7:0] OFS_RX_STATUS = 8'h40;
	localparam logic [7:0] OFS_TX_STATUS = 8'h48;
	localparam logic [7:0] OFS_BYTE_TEST = 8'h64;
	localparam logic [7:0] OFS_RX_LEVELS = 8'h7C;
	localparam logic [7:0] OFS_TX_LEVELS = 8'h80;
	localparam logic [7:0] OFS_PM_CTRL = 8'h84;
	// ----------------------------------------------------------------
	// field positions in the power management control register and the fifo level registers
	// ----------------------------------------------------------------
	localparam int POS_STATE = 12;
	localparam int POS_TRANSCEIVER_RESET_REQUEST = 10;
	localparam int POS_LAN_WAKE_ENABLE = 9;
	localparam int POS_ENERGY_DETECT_ENABLE = 8;
	localparam int POS_TYPE = 6;
	localparam int POS_CAUSE = 4;
	localparam int POS_PULSE = 3;
	localparam int POS_POL = 2;
	localparam int POS_OUT_EN = 1;
	localparam int POS_READY = 0;
	localparam int POS_USED = 16;
	// ----------------------------------------------------------------
	// reset values and word size
	// ----------------------------------------------------------------
	localparam logic [15:0] TX_FREE_RESET = 16'h1200;
	localparam logic [15:0] WORD_BYTES = 16'h0004;
	localparam int READY_CYCLES = 16;
	// ----------------------------------------------------------------
	// timing, 100 MHz clock
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int TRANSCEIVER_RESET_REQUEST_US = 100;
	localparam int TRANSCEIVER_RESET_REQUEST_CYCLES = TRANSCEIVER_RESET_REQUEST_US * CLK_MHZ;
	localparam int PULSE_MS = 50;
	localparam int PULSE_CYCLES = PULSE_MS * 1000 * CLK_MHZ;
	// ----------------------------------------------------------------
	// host end command registers
	// ----------------------------------------------------------------
	localparam logic [7:0] HOFS_ADDR = 8'h00;
	localparam logic [7:0] HOFS_WDATA = 8'h04;
	localparam logic [7:0] HOFS_GO = 8'h08;
	localparam logic [7:0] HOFS_STATUS = 8'h0C;
	localparam logic [7:0] HOFS_RESULT = 8'h10;
	localparam logic [7:0] HOFS_TX_FREE = 8'h14;
	// ----------------------------------------------------------------
	// enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FULL_POWER_STATE = 2'b00,
		FRAME_WAKE_STATE = 2'b01,
		ENERGY_WAKE_STATE = 2'b10
	} power_state_type;
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_PRE_RD = 3'b001,
		H_PRE_CAP = 3'b010,
		H_ACC = 3'b011,
		H_CAP = 3'b100
	} host_state_type;
endpackage : fifo_pm_pkg

// *** rtl/fifo_pm_if.sv ***
// register link between host end and device end
`timescale 1ns/1ns
`default_nettype none
interface fifo_pm_if;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	modport host (output addr, output wdata, output wr, output rd, input rdata);
	modport device (input addr, input wdata, input wr, input rd, output rdata);
endinterface : fifo_pm_if
`default_nettype wire

// *** rtl/fifo_pm_dev.sv ***
// device end: fifo level registers and power management control
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module fifo_pm_dev #(
	parameter int TRANSCEIVER_RESET_REQUEST_CYCLES = fifo_pm_pkg::TRANSCEIVER_RESET_REQUEST_CYCLES,
	parameter int PULSE_CYCLES = fifo_pm_pkg::PULSE_CYCLES,
	parameter int READY_CYCLES = fifo_pm_pkg::READY_CYCLES
) (
	input wire logic MCLK_I,
	input wire logic RST_B_I,
	fifo_pm_if.device LINK,
	input wire logic RX_FRAME_I,
	input wire logic [15:0] RX_FRAME_LEN_I,
	input wire logic RX_STATUS_PUSH_I,
	input wire logic TX_STATUS_PUSH_I,
	input wire logic TX_DRAIN_I,
	input wire logic WOL_EVENT_I,
	input wire logic ENERGY_EVENT_I,
	output logic WAKE_PIN_O,
	output logic WAKE_PIN_OE_O,
	output logic WAKE_INTERRUPT_O,
	output logic PHY_RESET_O,
	output logic [1:0] POWER_STATE_O,
	output logic READY_O
);
	// ----------------------------------------------------------------
	// access decode
	// ----------------------------------------------------------------
	localparam logic [7:0] READY_LOAD = 8'(READY_CYCLES);
	localparam logic [31:0] PHY_LAST = 32'(TRANSCEIVER_RESET_REQUEST_CYCLES - 1);
	localparam logic [31:0] PULSE_LOAD = 32'(PULSE_CYCLES);
	fifo_pm_pkg::power_state_type state_r;
	logic read_seen_r, ready_r, transceiver_reset_request_r;
	logic [7:0] ready_cnt_r;
	logic [31:0] phy_cnt_r, pulse_cnt_r;
	logic lan_wake_enable_r, energy_detect_enable_r, push_pull_r, pulse_sel_r, pol_r, out_en_r;
	logic [1:0] cause_r, cause_set, cause_clr, cause_nxt;
	logic [7:0] rx_status_used_words_r, tx_status_used_words_r;
	logic [15:0] rx_data_used_bytes_r, tx_data_free_bytes_r, rx_add;
	logic wr_ok, pm_wr, wake_wr, sleep_wr, rd_ok, asserted, cause_active;
	logic [1:0] wr_state;
	// writes need a prior read; in reduced power only the wake write acts, read or not
	assign wr_ok = LINK.wr & read_seen_r;
	assign wr_state = LINK.wdata[fifo_pm_pkg::POS_STATE +: 2];
	assign pm_wr = wr_ok & ready_r & (LINK.addr == fifo_pm_pkg::OFS_PM_CTRL);
	assign wake_wr = LINK.wr & (state_r != fifo_pm_pkg::FULL_POWER_STATE)
		& (LINK.addr == fifo_pm_pkg::OFS_BYTE_TEST);
	assign sleep_wr = pm_wr & (wr_state == fifo_pm_pkg::FRAME_WAKE_STATE
		| wr_state == fifo_pm_pkg::ENERGY_WAKE_STATE);
	assign rd_ok = LINK.rd & ready_r;
	// ----------------------------------------------------------------
	// power state, ready and read-before-write tracking
	// ----------------------------------------------------------------
	// state select clears itself back to full power on the wake write
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state_r <= fifo_pm_pkg::FULL_POWER_STATE;
		end else if (wake_wr) begin
			state_r <= fifo_pm_pkg::FULL_POWER_STATE;
		end else if (sleep_wr) begin
			state_r <= fifo_pm_pkg::power_state_type'(wr_state);
		end
	end
	// ready rises a fixed settle time after reset or wake
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ready_cnt_r <= READY_LOAD;
			ready_r <= 1'b0;
		end else if (sleep_wr | wake_wr) begin
			ready_cnt_r <= READY_LOAD;
			ready_r <= 1'b0;
		end else if (state_r == fifo_pm_pkg::FULL_POWER_STATE) begin
			if (ready_cnt_r != 8'h00) begin
				ready_cnt_r <= ready_cnt_r - 8'h01;
			end
			ready_r <= (ready_cnt_r == 8'h00);
		end
	end
	// any read arms writes; reset and a power transition disarm them
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			read_seen_r <= 1'b0;
		end else if (sleep_wr | wake_wr) begin
			read_seen_r <= 1'b0;
		end else if (LINK.rd) begin
			read_seen_r <= 1'b1;
		end
	end
	// ----------------------------------------------------------------
	// configuration bits and transceiver reset
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			{lan_wake_enable_r, energy_detect_enable_r, push_pull_r, pulse_sel_r, pol_r, out_en_r} <= 6'h00;
		end else if (pm_wr) begin
			lan_wake_enable_r <= LINK.wdata[fifo_pm_pkg::POS_LAN_WAKE_ENABLE];
			energy_detect_enable_r <= LINK.wdata[fifo_pm_pkg::POS_ENERGY_DETECT_ENABLE];
			push_pull_r <= LINK.wdata[fifo_pm_pkg::POS_TYPE];
			pulse_sel_r <= LINK.wdata[fifo_pm_pkg::POS_PULSE];
			pol_r <= LINK.wdata[fifo_pm_pkg::POS_POL];
			out_en_r <= LINK.wdata[fifo_pm_pkg::POS_OUT_EN];
		end
	end
	// a write of one while already in reset is ignored, so the hold is never cut short
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			transceiver_reset_request_r <= 1'b0;
			phy_cnt_r <= 32'h0000_0000;
		end else if (transceiver_reset_request_r) begin
			phy_cnt_r <= phy_cnt_r + 32'h0000_0001;
			if (phy_cnt_r == PHY_LAST) begin
				transceiver_reset_request_r <= 1'b0;
			end
		end else if (pm_wr & LINK.wdata[fifo_pm_pkg::POS_TRANSCEIVER_RESET_REQUEST]) begin
			transceiver_reset_request_r <= 1'b1;
			phy_cnt_r <= 32'h0000_0000;
		end
	end
	// ----------------------------------------------------------------
	// wake cause, interrupt and wake pin
	// ----------------------------------------------------------------
	// bit 1 frame/magic, bit 0 energy; both set reads as multiple events
	assign cause_set = {WOL_EVENT_I & lan_wake_enable_r, ENERGY_EVENT_I & energy_detect_enable_r};
	// clearing waits for full power, ready and quiet sources; a new event wins
	assign cause_clr = {2{pm_wr & state_r == fifo_pm_pkg::FULL_POWER_STATE}}
		& LINK.wdata[fifo_pm_pkg::POS_CAUSE +: 2]
		& ~{WOL_EVENT_I, ENERGY_EVENT_I};
	assign cause_nxt = (cause_r & ~cause_clr) | cause_set;
	assign cause_active = (cause_r[1] & lan_wake_enable_r) | (cause_r[0] & energy_detect_enable_r);
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			cause_r <= 2'b00;
		end else begin
			cause_r <= cause_nxt;
		end
	end
	// pulse timer restarts on each new event
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			pulse_cnt_r <= 32'h0000_0000;
		end else if (|cause_set) begin
			pulse_cnt_r <= PULSE_LOAD;
		end else if (pulse_cnt_r != 32'h0000_0000) begin
			pulse_cnt_r <= pulse_cnt_r - 32'h0000_0001;
		end
	end
	// output enable gates the pin only, never the interrupt
	assign asserted = out_en_r & cause_active
		& (~pulse_sel_r | (pulse_cnt_r != 32'h0000_0000));
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			WAKE_PIN_O <= 1'b0;
			WAKE_PIN_OE_O <= 1'b0;
			WAKE_INTERRUPT_O <= 1'b0;
		end else begin
			WAKE_INTERRUPT_O <= cause_active;
			if (push_pull_r) begin
				WAKE_PIN_OE_O <= 1'b1;
				WAKE_PIN_O <= pol_r ? asserted : ~asserted;
			end else begin
				WAKE_PIN_OE_O <= asserted;
				WAKE_PIN_O <= 1'b0;
			end
		end
	end
	// ----------------------------------------------------------------
	// fifo levels
	// ----------------------------------------------------------------
	// a frame adds its length rounded up to whole words
	assign rx_add = RX_FRAME_I ? ((RX_FRAME_LEN_I + 16'h0003) & 16'hFFFC) : 16'h0000;
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rx_data_used_bytes_r <= 16'h0000;
			rx_status_used_words_r <= 8'h00;
			tx_status_used_words_r <= 8'h00;
			tx_data_free_bytes_r <= fifo_pm_pkg::TX_FREE_RESET;
		end else begin
			rx_data_used_bytes_r <= rx_data_used_bytes_r + rx_add
				- ((rd_ok & LINK.addr == fifo_pm_pkg::OFS_RX_DATA
				& rx_data_used_bytes_r != 16'h0000) ? fifo_pm_pkg::WORD_BYTES : 16'h0000);
			rx_status_used_words_r <= rx_status_used_words_r + {7'h00, RX_STATUS_PUSH_I}
				- {7'h00, rd_ok & LINK.addr == fifo_pm_pkg::OFS_RX_STATUS
				& rx_status_used_words_r != 8'h00};
			tx_status_used_words_r <= tx_status_used_words_r + {7'h00, TX_STATUS_PUSH_I}
				- {7'h00, rd_ok & LINK.addr == fifo_pm_pkg::OFS_TX_STATUS
				& tx_status_used_words_r != 8'h00};
			tx_data_free_bytes_r <= tx_data_free_bytes_r
				+ (TX_DRAIN_I ? fifo_pm_pkg::WORD_BYTES : 16'h0000)
				- ((wr_ok & ready_r & LINK.addr == fifo_pm_pkg::OFS_TX_DATA)
				? fifo_pm_pkg::WORD_BYTES : 16'h0000);
		end
	end
	// ----------------------------------------------------------------
	// read data, one cycle after the strobe
	// ----------------------------------------------------------------
	// only the power register answers while not ready; other reads give zero
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			LINK.rdata <= 32'h0000_0000;
		end else if (LINK.rd & LINK.addr == fifo_pm_pkg::OFS_PM_CTRL) begin
			LINK.rdata <= {18'h00000, state_r, 1'b0, transceiver_reset_request_r, lan_wake_enable_r, energy_detect_enable_r, 1'b0,
				push_pull_r, cause_r, pulse_sel_r, pol_r, out_en_r, ready_r};
		end else if (rd_ok & LINK.addr == fifo_pm_pkg::OFS_RX_LEVELS) begin
			LINK.rdata <= {8'h00, rx_status_used_words_r, rx_data_used_bytes_r};
		end else if (rd_ok & LINK.addr == fifo_pm_pkg::OFS_TX_LEVELS) begin
			LINK.rdata <= {8'h00, tx_status_used_words_r, tx_data_free_bytes_r};
		end else begin
			LINK.rdata <= 32'h0000_0000;
		end
	end
	// ----------------------------------------------------------------
	// status outputs
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			PHY_RESET_O <= 1'b0;
			POWER_STATE_O <= 2'b00;
			READY_O <= 1'b0;
		end else begin
			PHY_RESET_O <= transceiver_reset_request_r;
			POWER_STATE_O <= state_r;
			READY_O <= ready_r;
		end
	end
endmodule : fifo_pm_dev
`default_nettype wire

// *** rtl/fifo_pm_host.sv ***
// host end: drives the register link on orders from its own command registers
`timescale 1ns/1ns
`default_nettype none
module fifo_pm_host (
	input wire logic MCLK_I,
	input wire logic RST_B_I,
	fifo_pm_if.host LINK,
	input wire logic [7:0] CMD_ADDR_I,
	input wire logic [31:0] CMD_WDATA_I,
	input wire logic CMD_WR_I,
	input wire logic CMD_RD_I,
	output logic [31:0] CMD_RDATA_O
);
	// ----------------------------------------------------------------
	// command registers
	// ----------------------------------------------------------------
	fifo_pm_pkg::host_state_type state_r;
	logic [7:0] addr_r;
	logic [31:0] wdata_r, result_r;
	logic op_rd_r, refused_r, read_seen_r, ready_known_r;
	logic [15:0] tx_free_r;
	logic go, go_rd, go_wr, refuse, cap, power_wr;
	assign go = CMD_WR_I & (CMD_ADDR_I == fifo_pm_pkg::HOFS_GO) & (state_r == fifo_pm_pkg::H_IDLE);
	assign go_rd = go & CMD_WDATA_I[0];
	assign go_wr = go & ~CMD_WDATA_I[0] & CMD_WDATA_I[1];
	// refuse writes that the device may not see yet, or that overfill tx data
	assign refuse = go_wr & ((~ready_known_r & addr_r != fifo_pm_pkg::OFS_BYTE_TEST)
		| (addr_r == fifo_pm_pkg::OFS_TX_DATA & tx_free_r < fifo_pm_pkg::WORD_BYTES));
	assign cap = (state_r == fifo_pm_pkg::H_PRE_CAP) | (state_r == fifo_pm_pkg::H_CAP & op_rd_r);
	assign power_wr = (state_r == fifo_pm_pkg::H_ACC) & ~op_rd_r
		& (addr_r == fifo_pm_pkg::OFS_BYTE_TEST | (addr_r == fifo_pm_pkg::OFS_PM_CTRL
		& ^wdata_r[fifo_pm_pkg::POS_STATE +: 2]));
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			addr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
		end else if (CMD_WR_I & state_r == fifo_pm_pkg::H_IDLE) begin
			if (CMD_ADDR_I == fifo_pm_pkg::HOFS_ADDR) begin
				addr_r <= CMD_WDATA_I[7:0];
			end
			if (CMD_ADDR_I == fifo_pm_pkg::HOFS_WDATA) begin
				wdata_r <= CMD_WDATA_I;
			end
		end
	end
	// sticky refusal, cleared by writing one to status bit 1; a new refusal wins
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			refused_r <= 1'b0;
		end else if (refuse) begin
			refused_r <= 1'b1;
		end else if (CMD_WR_I & CMD_ADDR_I == fifo_pm_pkg::HOFS_STATUS & CMD_WDATA_I[1]) begin
			refused_r <= 1'b0;
		end
	end
	// ----------------------------------------------------------------
	// link sequencer
	// ----------------------------------------------------------------
	// a write with no read since reset or wake is preceded by a power register read
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state_r <= fifo_pm_pkg::H_IDLE;
			op_rd_r <= 1'b0;
			LINK.addr <= 8'h00;
			LINK.wdata <= 32'h0000_0000;
			LINK.wr <= 1'b0;
			LINK.rd <= 1'b0;
		end else begin
			LINK.wr <= 1'b0;
			LINK.rd <= 1'b0;
			case (state_r)
				fifo_pm_pkg::H_IDLE: begin
					if ((go_rd | go_wr) & ~refuse) begin
						op_rd_r <= go_rd;
						if (go_wr & ~read_seen_r) begin
							LINK.addr <= fifo_pm_pkg::OFS_PM_CTRL;
							LINK.rd <= 1'b1;
							state_r <= fifo_pm_pkg::H_PRE_RD;
						end else begin
							LINK.addr <= addr_r;
							LINK.wdata <= wdata_r;
							LINK.rd <= go_rd;
							LINK.wr <= go_wr;
							state_r <= fifo_pm_pkg::H_ACC;
						end
					end
				end
				fifo_pm_pkg::H_PRE_RD: state_r <= fifo_pm_pkg::H_PRE_CAP;
				fifo_pm_pkg::H_PRE_CAP: begin
					LINK.addr <= addr_r;
					LINK.wdata <= wdata_r;
					LINK.wr <= 1'b1;
					state_r <= fifo_pm_pkg::H_ACC;
				end
				fifo_pm_pkg::H_ACC: state_r <= fifo_pm_pkg::H_CAP;
				default: state_r <= fifo_pm_pkg::H_IDLE;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// what the host knows of the device
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			read_seen_r <= 1'b0;
			ready_known_r <= 1'b0;
			tx_free_r <= fifo_pm_pkg::TX_FREE_RESET;
			result_r <= 32'h0000_0000;
		end else begin
			if (power_wr) begin
				read_seen_r <= 1'b0;
				ready_known_r <= 1'b0;
			end else if (cap) begin
				read_seen_r <= 1'b1;
				if (LINK.addr == fifo_pm_pkg::OFS_PM_CTRL) begin
					ready_known_r <= LINK.rdata[fifo_pm_pkg::POS_READY];
				end
			end
			if (cap & LINK.addr == fifo_pm_pkg::OFS_TX_LEVELS) begin
				tx_free_r <= LINK.rdata[15:0];
			end else if (state_r == fifo_pm_pkg::H_ACC & ~op_rd_r
				& addr_r == fifo_pm_pkg::OFS_TX_DATA) begin
				tx_free_r <= tx_free_r - fifo_pm_pkg::WORD_BYTES;
			end
			if (cap) begin
				result_r <= LINK.rdata;
			end
		end
	end
	// ----------------------------------------------------------------
	// user read port, data one cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			CMD_RDATA_O <= 32'h0000_0000;
		end else if (CMD_RD_I) begin
			case (CMD_ADDR_I)
				fifo_pm_pkg::HOFS_ADDR: CMD_RDATA_O <= {24'h000000, addr_r};
				fifo_pm_pkg::HOFS_WDATA: CMD_RDATA_O <= wdata_r;
				fifo_pm_pkg::HOFS_STATUS: CMD_RDATA_O <= {28'h0000000, read_seen_r,
					ready_known_r, refused_r, state_r != fifo_pm_pkg::H_IDLE};
				fifo_pm_pkg::HOFS_RESULT: CMD_RDATA_O <= result_r;
				fifo_pm_pkg::HOFS_TX_FREE: CMD_RDATA_O <= {16'h0000, tx_free_r};
				default: CMD_RDATA_O <= 32'h0000_0000;
			endcase
		end else begin
			CMD_RDATA_O <= 32'h0000_0000;
		end
	end
endmodule : fifo_pm_host
`default_nettype wire

// *** verif/fifo_pm_checker.sv ***
// assertions on the register link and the device status outputs
`timescale 1ns/1ns
`default_nettype none
module fifo_pm_checker #(
	parameter int TRANSCEIVER_RESET_REQUEST_CYCLES = fifo_pm_pkg::TRANSCEIVER_RESET_REQUEST_CYCLES
) (
	input wire logic MCLK_I,
	input wire logic RST_B_I,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic PHY_RESET_O,
	input wire logic [1:0] POWER_STATE_O,
	input wire logic READY_O
);
	int rst_len;
	logic [1:0] phy_req_r;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_B_I);
	// length of the current transceiver reset and the write that may have started it
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rst_len <= 0;
			phy_req_r <= 2'b00;
		end else begin
			rst_len <= PHY_RESET_O ? rst_len + 1 : 0;
			phy_req_r <= {phy_req_r[0], wr && addr == fifo_pm_pkg::OFS_PM_CTRL && wdata[10]};
		end
	end
	// a sleep request is only honoured when 01 or 10 is written while ready
	sequence s_sleep_wr;
		wr && addr == fifo_pm_pkg::OFS_PM_CTRL && (wdata[13] ^ wdata[12]) && READY_O;
	endsequence
	sequence s_wake_wr;
		wr && addr == fifo_pm_pkg::OFS_BYTE_TEST && !READY_O;
	endsequence
	property p_one_strobe; !(rd && wr); endproperty
	property p_strobe_apart; (rd || wr) |=> !(rd || wr); endproperty
	property p_phy_len; $fell(PHY_RESET_O) |-> rst_len == TRANSCEIVER_RESET_REQUEST_CYCLES; endproperty
	property p_phy_cause; $rose(PHY_RESET_O) |-> phy_req_r != 2'b00; endproperty
	property p_state_legal; POWER_STATE_O != 2'b11; endproperty
	property p_asleep; POWER_STATE_O != 2'b00 |-> !READY_O; endproperty
	property p_sleep; s_sleep_wr |-> ##[1:3] (!READY_O && POWER_STATE_O != 2'b00); endproperty
	property p_wake_settle; s_wake_wr |=> !READY_O [*8]; endproperty
	property p_wake; s_wake_wr |-> ##[1:40] (READY_O && POWER_STATE_O == 2'b00); endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("read and write together");
	a_strobe_apart: assert property (p_strobe_apart) else $error("strobes back to back");
	a_phy_len: assert property (p_phy_len) else $error("phy reset length");
	a_phy_cause: assert property (p_phy_cause) else $error("phy reset unasked");
	a_state_legal: assert property (p_state_legal) else $error("reserved state");
	a_asleep: assert property (p_asleep) else $error("ready while asleep");
	a_sleep: assert property (p_sleep) else $error("sleep not entered");
	a_wake_settle: assert property (p_wake_settle) else $error("ready too soon");
	a_wake: assert property (p_wake) else $error("no wake on byte test");
endmodule : fifo_pm_checker
`default_nettype wire

// *** verif/fifo_level_and_power_mgmt_regs_tb.sv ***
// testbench joining host end and device end over the register link
`timescale 1ns/1ns
`default_nettype none
module fifo_level_and_power_mgmt_regs_tb;
	logic mclk = 1'b0, rst_b = 1'b0, rx_frame = 1'b0, rxs_push = 1'b0, txs_push = 1'b0;
	logic tx_drain = 1'b0, wol_ev = 1'b0, ed_ev = 1'b0, c_wr = 1'b0, c_rd = 1'b0, phy_seen = 1'b0;
	logic [15:0] rx_len = 16'h0000;
	logic [7:0] c_addr = 8'h00;
	logic [31:0] c_wdata = 32'h00000000, c_rdata;
	logic pin, pin_oe, irq, transceiver_reset_request, ready;
	logic [1:0] pstate;
	int n_fail = 0, n_tests = 0;
	fifo_pm_if link_if();
	fifo_pm_dev #(.TRANSCEIVER_RESET_REQUEST_CYCLES(20), .PULSE_CYCLES(30), .READY_CYCLES(16)) fifo_pm_dev_i (
		.MCLK_I(mclk), .RST_B_I(rst_b), .LINK(link_if), .RX_FRAME_I(rx_frame),
		.RX_FRAME_LEN_I(rx_len), .RX_STATUS_PUSH_I(rxs_push), .TX_STATUS_PUSH_I(txs_push),
		.TX_DRAIN_I(tx_drain), .WOL_EVENT_I(wol_ev), .ENERGY_EVENT_I(ed_ev), .WAKE_PIN_O(pin),
		.WAKE_PIN_OE_O(pin_oe), .WAKE_INTERRUPT_O(irq), .PHY_RESET_O(transceiver_reset_request),
		.POWER_STATE_O(pstate), .READY_O(ready));
	fifo_pm_host fifo_pm_host_i (.MCLK_I(mclk), .RST_B_I(rst_b), .LINK(link_if),
		.CMD_ADDR_I(c_addr), .CMD_WDATA_I(c_wdata), .CMD_WR_I(c_wr), .CMD_RD_I(c_rd),
		.CMD_RDATA_O(c_rdata));
	fifo_pm_checker #(.TRANSCEIVER_RESET_REQUEST_CYCLES(20)) fifo_pm_checker_i (.MCLK_I(mclk), .RST_B_I(rst_b),
		.addr(link_if.addr), .wdata(link_if.wdata), .wr(link_if.wr), .rd(link_if.rd),
		.PHY_RESET_O(transceiver_reset_request), .POWER_STATE_O(pstate), .READY_O(ready));
	initial begin
		forever #5 mclk = ~mclk;
	end
	// the reset pulse may end before a link read can look, so remember it
	always @(posedge mclk) if (transceiver_reset_request === 1'b1) phy_seen <= 1'b1;
	task automatic conclude();
		if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : conclude
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// one strobe on the host user port; read data stand in the cycle after the strobe
	task automatic cmd(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge mclk);
		c_addr <= a;
		c_wdata <= d;
		c_wr <= w;
		c_rd <= !w;
		@(posedge mclk);
		c_wr <= 1'b0;
		c_rd <= 1'b0;
		@(posedge mclk);
		q = c_rdata;
	endtask : cmd
	// one link transfer ordered through the host end, polling busy under a bound
	task automatic link(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		logic [31:0] s;
		cmd(1'b1, fifo_pm_pkg::HOFS_ADDR, {24'h000000, a}, s);
		cmd(1'b1, fifo_pm_pkg::HOFS_WDATA, d, s);
		cmd(1'b1, fifo_pm_pkg::HOFS_GO, w ? 32'h00000002 : 32'h00000001, s);
		s = 32'h00000001;
		for (int i = 0; i < 40 && s[0] !== 1'b0; i++) cmd(1'b0, fifo_pm_pkg::HOFS_STATUS, 0, s);
		check("link busy refused", 32'h00000000, {30'h0, s[1:0]});
		cmd(1'b0, fifo_pm_pkg::HOFS_RESULT, 32'h00000000, q);
	endtask : link
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		link(1'b0, a, 32'h00000000, q);
		check(what, exp, q);
	endtask : rdchk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		link(1'b1, a, d, q);
	endtask : wr
	task automatic t_levels();
		@(posedge mclk);
		rx_frame <= 1'b1;
		rx_len <= 16'h0005;
		rxs_push <= 1'b1;
		txs_push <= 1'b1;
		@(posedge mclk);
		rx_frame <= 1'b0;
		rxs_push <= 1'b0;
		txs_push <= 1'b0;
		wr(fifo_pm_pkg::OFS_TX_DATA, 32'hA5A5A5A5);
		rdchk("rx levels", fifo_pm_pkg::OFS_RX_LEVELS, 32'h00010008);
		rdchk("tx levels", fifo_pm_pkg::OFS_TX_LEVELS, 32'h000111FC);
		rdchk("rx pop", fifo_pm_pkg::OFS_RX_DATA, 32'h00000000);
		rdchk("rx status pop", fifo_pm_pkg::OFS_RX_STATUS, 32'h00000000);
		rdchk("tx status pop", fifo_pm_pkg::OFS_TX_STATUS, 32'h00000000);
		@(posedge mclk);
		tx_drain <= 1'b1;
		@(posedge mclk);
		tx_drain <= 1'b0;
		rdchk("rx levels after pops", fifo_pm_pkg::OFS_RX_LEVELS, 32'h00000004);
		rdchk("tx levels after drain", fifo_pm_pkg::OFS_TX_LEVELS, 32'h00001200);
	endtask : t_levels
	task automatic t_phy();
		wr(fifo_pm_pkg::OFS_PM_CTRL, 32'h00000400);
		repeat (30) @(posedge mclk);
		check("phy reset seen", 32'h1, {31'h0, phy_seen});
		rdchk("phy bit cleared", fifo_pm_pkg::OFS_PM_CTRL, 32'h00000001);
	endtask : t_phy
	// energy wake in push-pull active-low level mode, then a clear of the cause
	task automatic t_energy();
		wr(fifo_pm_pkg::OFS_PM_CTRL, 32'h00000142);
		@(posedge mclk);
		ed_ev <= 1'b1;
		@(posedge mclk);
		ed_ev <= 1'b0;
		repeat (4) @(posedge mclk);
		check("energy pin", 32'h00000102, {23'h0, irq, 6'h0, pin_oe, pin});
		rdchk("energy cause", fifo_pm_pkg::OFS_PM_CTRL, 32'h00000153);
		wr(fifo_pm_pkg::OFS_PM_CTRL, 32'h00000152);
		repeat (4) @(posedge mclk);
		check("cleared pin", 32'h00000003, {23'h0, irq, 6'h0, pin_oe, pin});
	endtask : t_energy
	// both events, open drain, pulse mode: the pin lets go while the cause stays
	task automatic t_multi();
		wr(fifo_pm_pkg::OFS_PM_CTRL, 32'h0000030A);
		@(posedge mclk);
		ed_ev <= 1'b1;
		wol_ev <= 1'b1;
		@(posedge mclk);
		ed_ev <= 1'b0;
		wol_ev <= 1'b0;
		repeat (4) @(posedge mclk);
		check("od active", 32'h00000102, {23'h0, irq, 6'h0, pin_oe, pin});
		repeat (40) @(posedge mclk);
		check("pulse over", 32'h00000100, {23'h0, irq, 6'h0, pin_oe, pin});
		rdchk("both causes", fifo_pm_pkg::OFS_PM_CTRL, 32'h0000033B);
		wr(fifo_pm_pkg::OFS_PM_CTRL, 32'h0000033A);
		repeat (4) @(posedge mclk);
		check("irq cleared", 32'h0, {31'h0, irq});
	endtask : t_multi
	task automatic t_sleep();
		wr(fifo_pm_pkg::OFS_PM_CTRL, 32'h00003000);
		repeat (4) @(posedge mclk);
		check("reserved state", 32'h00000001, {22'h0, pstate, 7'h0, ready});
		for (int st = 1; st < 3; st++) begin
			wr(fifo_pm_pkg::OFS_PM_CTRL, 32'(st) << 12);
			repeat (4) @(posedge mclk);
			check("asleep", 32'(st) << 8, {22'h0, pstate, 7'h0, ready});
			wr(fifo_pm_pkg::OFS_BYTE_TEST, 32'h00000000);
			repeat (30) @(posedge mclk);
			check("awake", 32'h00000001, {22'h0, pstate, 7'h0, ready});
			rdchk("pm awake", fifo_pm_pkg::OFS_PM_CTRL, 32'h00000001);
		end
	endtask : t_sleep
	initial begin
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (30) @(posedge mclk);
		rdchk("pm after reset", fifo_pm_pkg::OFS_PM_CTRL, 32'h00000001);
		rdchk("rx reset", fifo_pm_pkg::OFS_RX_LEVELS, 32'h00000000);
		rdchk("tx reset", fifo_pm_pkg::OFS_TX_LEVELS, 32'h00001200);
		t_levels();
		t_phy();
		t_energy();
		t_multi();
		t_sleep();
		conclude();
	end
	// bounds a hang at roughly eighty times the expected run
	initial begin
		#500000;
		n_fail++;
		conclude();
	end
endmodule : fifo_level_and_power_mgmt_regs_tb
`default_nettype wire
